// ===== rtl/mdr_pkg.sv
package mdr_pkg;
  // Register offsets
  localparam logic [7:0] OFS_PULLUP_SELECT = 8'h52;
  localparam logic [7:0] OFS_PULLDOWN_SELECT = 8'h53;
  localparam logic [7:0] OFS_CHAN1_FLAGS = 8'h54;
  localparam logic [7:0] OFS_CHAN1_LEVEL = 8'h55;
  localparam logic [7:0] OFS_CHAN2_FLAGS = 8'h56;
  localparam logic [7:0] OFS_CHAN2_LEVEL = 8'h57;

  // Field widths and reset values
  localparam int PULLUP_W = 6;
  localparam int PULLDOWN_W = 7;
  localparam logic [5:0] RST_PULLUP_SELECT = 6'h00;
  localparam logic [6:0] RST_PULLDOWN_SELECT = 7'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_LEVEL = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Result flag field positions
  localparam int GND_BIT = 4;
  localparam int ABORT_BIT = 3;
  localparam int OPEN_BIT = 2;
  localparam int CUR_MSB = 1;
  localparam int CUR_LSB = 0;

  // Forced result values
  localparam logic [1:0] CUR_FORCED_LOW = 2'h0;
  localparam logic [1:0] CUR_FORCED_GROUND = 2'h3;
  localparam logic [7:0] LEVEL_FORCED_LOW = 8'h00;
  localparam logic [7:0] LEVEL_FORCED_OPEN = 8'hFF;

  // Pin masks for automatic configuration
  localparam logic [5:0] PU_CHAN1_PIN = 6'h01;
  localparam logic [5:0] PU_CHAN2_PIN = 6'h02;
  localparam logic [0:0] PD_BUS_SUPPLY_ON = 1'h1;

  // Periodic measurement timing
  localparam longint PERIOD_S = 10;
  localparam longint CLOCK_HZ = 100_000_000;
  localparam longint PERIOD_CYCLES_DEF = PERIOD_S * CLOCK_HZ;

  // Outcome of one burst measurement
  typedef enum logic [1:0] {
    OUT_RESISTIVE,
    OUT_GROUND,
    OUT_ABORT,
    OUT_OPEN
  } mdr_outcome_t;
endpackage

// ===== rtl/mdr_burst_result.sv
`timescale 1ns/1ps
module mdr_burst_result (
  input wire logic I_CLOCK, // Device clock
  input wire logic I_RST_B, // Async reset, active low
  input wire logic i_done, // Burst completed, one-cycle pulse
  input wire mdr_pkg::mdr_outcome_t i_outcome, // Burst outcome
  input wire logic [1:0] i_current, // Final pullup current code
  input wire logic [7:0] i_level, // Final ADC value
  output logic [7:0] o_flags, // Flags register image
  output logic [7:0] o_level // Level register image
);
  import mdr_pkg::*;

  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] level_reg;
  logic [7:0] level_next;

  // Forced values per outcome, one flag at most
  always_comb begin
    flags_next = RST_FLAGS;
    level_next = i_level;
    unique case (i_outcome)
      OUT_RESISTIVE: begin
        flags_next[CUR_MSB:CUR_LSB] = i_current;
      end
      OUT_GROUND: begin
        flags_next[GND_BIT] = 1'b1;
        flags_next[CUR_MSB:CUR_LSB] = CUR_FORCED_GROUND;
        level_next = LEVEL_FORCED_LOW;
      end
      OUT_ABORT: begin
        flags_next[ABORT_BIT] = 1'b1;
        flags_next[CUR_MSB:CUR_LSB] = CUR_FORCED_LOW;
        level_next = LEVEL_FORCED_LOW;
      end
      OUT_OPEN: begin
        flags_next[OPEN_BIT] = 1'b1;
        flags_next[CUR_MSB:CUR_LSB] = CUR_FORCED_LOW;
        level_next = LEVEL_FORCED_OPEN;
      end
    endcase
  end

  // Whole result captured in one edge so reads never mix bursts
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      flags_reg <= RST_FLAGS;
      level_reg <= RST_LEVEL;
    end else if (i_done) begin
      flags_reg <= flags_next;
      level_reg <= level_next;
    end
  end

  assign o_flags = flags_reg;
  assign o_level = level_reg;

  sequence s_done_as(mdr_outcome_t oc);
    i_done && i_outcome == oc;
  endsequence

  property p_ground;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    s_done_as(OUT_GROUND) |=> flags_reg == 8'h13 && level_reg == LEVEL_FORCED_LOW;
  endproperty
  a_ground: assert property (p_ground) else $error("ground result wrong");

  property p_abort;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    s_done_as(OUT_ABORT) |=> flags_reg == 8'h08 && level_reg == LEVEL_FORCED_LOW;
  endproperty
  a_abort: assert property (p_abort) else $error("abort result wrong");

  property p_open;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    s_done_as(OUT_OPEN) |=> flags_reg == 8'h04 && level_reg == LEVEL_FORCED_OPEN;
  endproperty
  a_open: assert property (p_open) else $error("open result wrong");

  property p_resistive;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    s_done_as(OUT_RESISTIVE) |=> flags_reg == {6'h00, $past(i_current)} && level_reg == $past(i_level);
  endproperty
  a_resistive: assert property (p_resistive) else $error("resistive result wrong");

  property p_hold;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    !i_done ##1 !i_done |-> $stable(flags_reg) && $stable(level_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed without burst");

  property p_single_flag;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    $onehot0(flags_reg[GND_BIT:OPEN_BIT]) && flags_reg[7:5] == 3'h0;
  endproperty
  a_single_flag: assert property (p_single_flag) else $error("more than one flag set");
endmodule

// ===== rtl/mdr_top.sv
`timescale 1ns/1ps
// Operation
// - The pullup select register drives the pullup force/sense switches only while automatic setup is off.
// - Pullup bits 0 to 5 serve channel 1, channel 2, sideband 1, sideband 2, charger plus and charger minus.
// - The pulldown select register drives the pulldown switches only while automatic setup is off.
// - Pulldown bits 0 to 5 follow the pullup pin order and bit 6 selects the bus supply pin.
// - Channel 1 flag bit 4 reads 1 when its latest burst ended as Ground.
// - Channel 1 flag bit 3 reads 1 only when its latest burst was aborted.
// - Channel 1 flag bit 2 reads 1 only when its latest burst found Open.
// - The final current field holds the burst current, forced to 0 on Abort or Open and to 3 on Ground.
// - Channel 1 level holds the last reading, forced to 0x00 on Abort or Ground and 0xFF on Open.
// - Channel 2 has its own read-only flags register with the same layout as channel 1.
// - With automatic setup on, one channel pin is pulled up and all other pins pulled down, alternating channels.
// - With periodic mode on, a measurement starts every 10 s while unattached and none while attached.
// - Channel 2 level holds the last reading, forced to 0x00 on Abort or Ground and 0xFF on Open.
module mdr_top #(
  parameter int unsigned PERIOD_CYCLES = 32'(mdr_pkg::PERIOD_CYCLES_DEF) // Cycles between periodic bursts
) (
  input wire logic I_CLOCK, // 100 MHz device clock
  input wire logic I_RST_B, // Async reset, active low
  input wire logic [7:0] I_REG_ADDR, // Register offset
  input wire logic I_REG_WR, // Write strobe
  input wire logic [7:0] I_REG_WDATA, // Write data
  input wire logic I_REG_RD, // Read strobe
  output logic [7:0] O_REG_RDATA, // Read data, valid after read strobe
  input wire logic I_WET_AUTO_SETUP_ENABLE, // Automatic switch setup
  input wire logic I_WET_PERIODIC_ENABLE, // Periodic measurement enable
  input wire logic I_UNATTACHED, // Port in unattached state
  input wire logic [1:0] I_BURST_DONE, // Burst done per channel
  input wire mdr_pkg::mdr_outcome_t I_CHAN1_OUTCOME, // Channel 1 outcome
  input wire mdr_pkg::mdr_outcome_t I_CHAN2_OUTCOME, // Channel 2 outcome
  input wire logic [1:0] I_CHAN1_CURRENT, // Channel 1 final current
  input wire logic [1:0] I_CHAN2_CURRENT, // Channel 2 final current
  input wire logic [7:0] I_CHAN1_LEVEL, // Channel 1 final ADC value
  input wire logic [7:0] I_CHAN2_LEVEL, // Channel 2 final ADC value
  output logic [5:0] O_PULLUP_SWITCH, // Pullup force/sense switch enables
  output logic [6:0] O_PULLDOWN_SWITCH, // Pulldown switch enables
  output logic O_AUTO_CHAN2, // Automatic setup measures channel 2
  output logic O_MEASURE_START // Periodic burst request pulse
);
  import mdr_pkg::*;

  localparam int TIMER_W = $clog2(PERIOD_CYCLES);

  // Elaboration checks
  if (PERIOD_CYCLES < 2) begin : g_bad_period
    $error("PERIOD_CYCLES must be at least 2");
  end

  logic [5:0] pullup_select_reg;
  logic [6:0] pulldown_select_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [5:0] pu_switch_reg;
  logic [5:0] pu_switch_next;
  logic [6:0] pd_switch_reg;
  logic [6:0] pd_switch_next;
  logic chan_sel_reg;
  logic chan_sel_next;
  logic [TIMER_W-1:0] timer_reg;
  logic [TIMER_W-1:0] timer_next;
  logic start_reg;
  logic start_next;
  logic [7:0] chan_flags [2];
  logic [7:0] chan_level [2];
  mdr_outcome_t chan_outcome [2];
  logic [1:0] chan_current [2];
  logic [7:0] chan_level_in [2];

  // Register address decode
  wire wr_pullup = I_REG_WR && I_REG_ADDR == OFS_PULLUP_SELECT;
  wire wr_pulldown = I_REG_WR && I_REG_ADDR == OFS_PULLDOWN_SELECT;

  // Software select registers; reserved bits are not stored
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pullup_select_reg <= RST_PULLUP_SELECT;
      pulldown_select_reg <= RST_PULLDOWN_SELECT;
    end else begin
      if (wr_pullup) begin
        pullup_select_reg <= I_REG_WDATA[PULLUP_W-1:0];
      end
      if (wr_pulldown) begin
        pulldown_select_reg <= I_REG_WDATA[PULLDOWN_W-1:0];
      end
    end
  end

  // Read mux; unmapped offsets and reserved bits read zero
  always_comb begin
    unique case (I_REG_ADDR)
      OFS_PULLUP_SELECT: rdata_next = {2'h0, pullup_select_reg};
      OFS_PULLDOWN_SELECT: rdata_next = {1'h0, pulldown_select_reg};
      OFS_CHAN1_FLAGS: rdata_next = chan_flags[0];
      OFS_CHAN1_LEVEL: rdata_next = chan_level[0];
      OFS_CHAN2_FLAGS: rdata_next = chan_flags[1];
      OFS_CHAN2_LEVEL: rdata_next = chan_level[1];
      default: rdata_next = READ_UNMAPPED;
    endcase
  end

  // Read data captured on the read strobe and held until the next one
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rdata_reg <= READ_UNMAPPED;
    end else if (I_REG_RD) begin
      rdata_reg <= rdata_next;
    end
  end

  // Automatic setup alternates channels after each completed burst of the selected channel
  assign chan_sel_next = chan_sel_reg ^ (I_WET_AUTO_SETUP_ENABLE && I_BURST_DONE[chan_sel_reg]);

  // Switch selection: manual registers or automatic pattern
  always_comb begin
    if (I_WET_AUTO_SETUP_ENABLE) begin
      pu_switch_next = chan_sel_next ? PU_CHAN2_PIN : PU_CHAN1_PIN;
      pd_switch_next = {PD_BUS_SUPPLY_ON, ~pu_switch_next};
    end else begin
      pu_switch_next = pullup_select_reg;
      pd_switch_next = pulldown_select_reg;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      chan_sel_reg <= 1'b0;
      pu_switch_reg <= RST_PULLUP_SELECT;
      pd_switch_reg <= RST_PULLDOWN_SELECT;
    end else begin
      chan_sel_reg <= chan_sel_next;
      pu_switch_reg <= pu_switch_next;
      pd_switch_reg <= pd_switch_next;
    end
  end

  // Periodic timer runs only while enabled and unattached
  wire timer_run = I_WET_PERIODIC_ENABLE && I_UNATTACHED;
  wire timer_wrap = timer_reg == TIMER_W'(PERIOD_CYCLES - 1);

  assign timer_next = (!timer_run || timer_wrap) ? '0 : timer_reg + 1'b1;
  assign start_next = timer_run && timer_wrap;

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      timer_reg <= '0;
      start_reg <= 1'b0;
    end else begin
      timer_reg <= timer_next;
      start_reg <= start_next;
    end
  end

  // Per-channel inputs gathered for the result latches
  assign chan_outcome[0] = I_CHAN1_OUTCOME;
  assign chan_outcome[1] = I_CHAN2_OUTCOME;
  assign chan_current[0] = I_CHAN1_CURRENT;
  assign chan_current[1] = I_CHAN2_CURRENT;
  assign chan_level_in[0] = I_CHAN1_LEVEL;
  assign chan_level_in[1] = I_CHAN2_LEVEL;

  // One result latch per configuration channel, same layout
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    mdr_burst_result u_result (
      .I_CLOCK(I_CLOCK),
      .I_RST_B(I_RST_B),
      .i_done(I_BURST_DONE[ch]),
      .i_outcome(chan_outcome[ch]),
      .i_current(chan_current[ch]),
      .i_level(chan_level_in[ch]),
      .o_flags(chan_flags[ch]),
      .o_level(chan_level[ch])
    );
  end

  // Outputs straight from flip-flops
  assign O_REG_RDATA = rdata_reg;
  assign O_PULLUP_SWITCH = pu_switch_reg;
  assign O_PULLDOWN_SWITCH = pd_switch_reg;
  assign O_AUTO_CHAN2 = chan_sel_reg;
  assign O_MEASURE_START = start_reg;

  // Helper: cycles since the run began, a start counting as the first cycle of the next gap
  logic [TIMER_W:0] gap_cnt_reg;
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      gap_cnt_reg <= '0;
    end else if (!timer_run) begin
      gap_cnt_reg <= '0;
    end else if (start_reg) begin
      gap_cnt_reg <= (TIMER_W + 1)'(1);
    end else begin
      gap_cnt_reg <= gap_cnt_reg + 1'b1;
    end
  end

  sequence s_manual;
    !I_WET_AUTO_SETUP_ENABLE;
  endsequence

  sequence s_auto;
    I_WET_AUTO_SETUP_ENABLE;
  endsequence

  sequence s_read_of(logic [7:0] ofs);
    I_REG_RD && I_REG_ADDR == ofs;
  endsequence

  property p_manual_pullup;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    s_manual |=> O_PULLUP_SWITCH == $past(pullup_select_reg);
  endproperty
  a_manual_pullup: assert property (p_manual_pullup) else $error("manual pullup mismatch");

  property p_manual_pulldown;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    s_manual |=> O_PULLDOWN_SWITCH == $past(pulldown_select_reg);
  endproperty
  a_manual_pulldown: assert property (p_manual_pulldown) else $error("manual pulldown mismatch");

  property p_write_to_switch;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    (wr_pullup && !I_WET_AUTO_SETUP_ENABLE) ##1 s_manual
      |=> O_PULLUP_SWITCH == $past(I_REG_WDATA[5:0], 2);
  endproperty
  a_write_to_switch: assert property (p_write_to_switch) else $error("pullup write not applied");

  property p_auto_pattern;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    s_auto |=> $onehot(O_PULLUP_SWITCH) && O_PULLUP_SWITCH[5:2] == 4'h0
      && O_PULLDOWN_SWITCH == {1'b1, ~O_PULLUP_SWITCH};
  endproperty
  a_auto_pattern: assert property (p_auto_pattern) else $error("auto switch pattern wrong");

  property p_auto_alternate;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    s_auto ##0 I_BURST_DONE[O_AUTO_CHAN2] |=> O_AUTO_CHAN2 != $past(O_AUTO_CHAN2);
  endproperty
  a_auto_alternate: assert property (p_auto_alternate) else $error("auto channel did not alternate");

  property p_auto_hold;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    s_auto ##0 !I_BURST_DONE[O_AUTO_CHAN2] |=> O_AUTO_CHAN2 == $past(O_AUTO_CHAN2);
  endproperty
  a_auto_hold: assert property (p_auto_hold) else $error("auto channel moved without burst");

  property p_manual_chan_hold;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    s_manual |=> $stable(O_AUTO_CHAN2);
  endproperty
  a_manual_chan_hold: assert property (p_manual_chan_hold) else $error("auto channel moved in manual mode");

  property p_no_start_attached;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    !timer_run |=> !O_MEASURE_START;
  endproperty
  a_no_start_attached: assert property (p_no_start_attached) else $error("start while attached");

  property p_period_gap;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    O_MEASURE_START |-> $past(gap_cnt_reg) == (TIMER_W + 1)'(PERIOD_CYCLES - 1);
  endproperty
  a_period_gap: assert property (p_period_gap) else $error("periodic start spacing wrong");

  property p_gap_bound;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    gap_cnt_reg <= (TIMER_W + 1)'(PERIOD_CYCLES);
  endproperty
  a_gap_bound: assert property (p_gap_bound) else $error("periodic start missed");

  property p_start_pulse;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    O_MEASURE_START |=> !O_MEASURE_START;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");

  property p_read_unmapped;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    I_REG_RD && (I_REG_ADDR < OFS_PULLUP_SELECT || I_REG_ADDR > OFS_CHAN2_LEVEL) |=> O_REG_RDATA == 8'h00;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

  property p_read_reserved;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    s_read_of(OFS_PULLUP_SELECT) |=> O_REG_RDATA[7:6] == 2'h0;
  endproperty
  a_read_reserved: assert property (p_read_reserved) else $error("reserved bits not zero");

  property p_read_pd_reserved;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    s_read_of(OFS_PULLDOWN_SELECT) |=> O_REG_RDATA[7] == 1'b0;
  endproperty
  a_read_pd_reserved: assert property (p_read_pd_reserved) else $error("pulldown reserved bit not zero");

  property p_read_chan1_flags;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    s_read_of(OFS_CHAN1_FLAGS) |=> O_REG_RDATA == $past(chan_flags[0]);
  endproperty
  a_read_chan1_flags: assert property (p_read_chan1_flags) else $error("channel 1 flags read wrong");

  property p_read_chan1_level;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    s_read_of(OFS_CHAN1_LEVEL) |=> O_REG_RDATA == $past(chan_level[0]);
  endproperty
  a_read_chan1_level: assert property (p_read_chan1_level) else $error("channel 1 level read wrong");

  property p_read_chan2_flags;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    s_read_of(OFS_CHAN2_FLAGS) |=> O_REG_RDATA == $past(chan_flags[1]);
  endproperty
  a_read_chan2_flags: assert property (p_read_chan2_flags) else $error("channel 2 flags read wrong");

  property p_read_chan2_level;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    s_read_of(OFS_CHAN2_LEVEL) |=> O_REG_RDATA == $past(chan_level[1]);
  endproperty
  a_read_chan2_level: assert property (p_read_chan2_level) else $error("channel 2 level read wrong");

  property p_read_hold;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
    !I_REG_RD |=> $stable(O_REG_RDATA);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data changed without read");
endmodule

// ===== bench/mdr_burst_model.sv
`timescale 1ns/1ps
module mdr_burst_model (
  input wire logic I_CLOCK, // Device clock
  output logic [1:0] o_burst_done, // Burst done per channel
  output mdr_pkg::mdr_outcome_t o_outcome, // Outcome for both channels
  output logic [1:0] o_current, // Final pullup current
  output logic [7:0] o_level // Final ADC value
);
  import mdr_pkg::*;

  // Quiet lines at start
  initial begin
    o_burst_done = 2'h0;
    o_outcome = OUT_RESISTIVE;
    o_current = 2'h0;
    o_level = 8'h00;
  end

  // One burst after a prompt or slow wait; data lines invert once done drops
  task automatic burst(input logic [1:0] chans, input mdr_outcome_t oc, input logic [1:0] cur,
                       input logic [7:0] lvl, input int wait_cycles);
    repeat (1 + wait_cycles) @(posedge I_CLOCK);
    o_burst_done <= chans;
    o_outcome <= oc;
    o_current <= cur;
    o_level <= lvl;
    @(posedge I_CLOCK);
    o_burst_done <= 2'h0;
    o_outcome <= mdr_outcome_t'(~oc);
    o_current <= ~cur;
    o_level <= ~lvl;
  endtask
endmodule

// ===== bench/mdr_top_bench.sv
`timescale 1ns/1ps
module mdr_top_bench;
  import mdr_pkg::*;
  localparam int unsigned PERIOD = 8;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic auto_en = 1'b0;
  logic per_en = 1'b0;
  logic unattached = 1'b0;
  logic [7:0] rdata;
  logic [5:0] pu_sw;
  logic [6:0] pd_sw;
  logic auto_ch2;
  logic meas_start;
  logic [1:0] done;
  mdr_outcome_t oc;
  logic [1:0] cur;
  logic [7:0] lvl;
  logic [7:0] exp_f [2];
  logic [7:0] exp_l [2];
  logic [7:0] got;
  logic [7:0] v;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;

  // Clock
  always #5 clock = ~clock;

  mdr_top #(.PERIOD_CYCLES(PERIOD)) dut_u (
    .I_CLOCK(clock), .I_RST_B(rst_b), .I_REG_ADDR(reg_addr), .I_REG_WR(reg_wr),
    .I_REG_WDATA(reg_wdata), .I_REG_RD(reg_rd), .O_REG_RDATA(rdata),
    .I_WET_AUTO_SETUP_ENABLE(auto_en), .I_WET_PERIODIC_ENABLE(per_en), .I_UNATTACHED(unattached),
    .I_BURST_DONE(done), .I_CHAN1_OUTCOME(oc), .I_CHAN2_OUTCOME(oc), .I_CHAN1_CURRENT(cur),
    .I_CHAN2_CURRENT(cur), .I_CHAN1_LEVEL(lvl), .I_CHAN2_LEVEL(lvl), .O_PULLUP_SWITCH(pu_sw),
    .O_PULLDOWN_SWITCH(pd_sw), .O_AUTO_CHAN2(auto_ch2), .O_MEASURE_START(meas_start)
  );

  mdr_burst_model model_u (
    .I_CLOCK(clock), .o_burst_done(done), .o_outcome(oc), .o_current(cur), .o_level(lvl)
  );

  // Expected flags image per outcome
  function automatic logic [7:0] exp_flags(input mdr_outcome_t o, input logic [1:0] c);
    case (o)
      OUT_GROUND: return 8'h13;
      OUT_ABORT: return 8'h08;
      OUT_OPEN: return 8'h04;
      default: return {6'h00, c};
    endcase
  endfunction

  // Expected level image per outcome
  function automatic logic [7:0] exp_level(input mdr_outcome_t o, input logic [7:0] l);
    case (o)
      OUT_GROUND, OUT_ABORT: return 8'h00;
      OUT_OPEN: return 8'hFF;
      default: return l;
    endcase
  endfunction

  task automatic check(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Burst through the model, tracking what each channel should hold
  task automatic fire(input logic [1:0] ch, input mdr_outcome_t o, input logic [1:0] c,
                      input logic [7:0] l, input int w);
    model_u.burst(ch, o, c, l, w);
    for (int k = 0; k < 2; k++) begin
      if (ch[k]) begin
        exp_f[k] = exp_flags(o, c);
        exp_l[k] = exp_level(o, l);
      end
    end
    #1;
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(59));
    exp_f = '{8'h00, 8'h00};
    exp_l = '{8'h00, 8'h00};
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    // Reset images, unmapped 0x58 included
    for (int a = 8'h52; a <= 8'h58; a++) begin
      rd(8'(a), got);
      check(got, 8'h00);
    end
    check({1'b0, pd_sw}, 8'h00);
    // Manual selects: walking ones with reserved bit 7, then random
    for (int i = 0; i < 14; i++) begin
      v = (i < 8) ? (8'h01 << i) : 8'($urandom);
      wr(OFS_PULLUP_SELECT, v);
      wr(OFS_PULLDOWN_SELECT, ~v);
      rd(OFS_PULLUP_SELECT, got);
      check(got, v & 8'h3F);
      rd(OFS_PULLDOWN_SELECT, got);
      check(got, ~v & 8'h7F);
      check({2'h0, pu_sw}, v & 8'h3F);
      check({1'b0, pd_sw}, ~v & 8'h7F);
    end
    // Writes to read-only and unmapped places are dropped
    wr(OFS_CHAN1_FLAGS, 8'hFF);
    wr(8'h60, 8'hFF);
    rd(OFS_CHAN1_FLAGS, got);
    check(got, 8'h00);
    rd(8'h60, got);
    check(got, 8'h00);
    // Automatic setup overrides the selects and alternates channels
    @(posedge clock);
    auto_en <= 1'b1;
    wr(OFS_PULLUP_SELECT, 8'h3F);
    wr(OFS_PULLDOWN_SELECT, 8'h00);
    #1;
    check({2'h0, pu_sw}, 8'h01);
    check({1'b0, pd_sw}, 8'h7E);
    fire(2'b10, OUT_RESISTIVE, 2'h1, 8'h33, 0);
    check({7'h00, auto_ch2}, 8'h00);
    fire(2'b01, OUT_OPEN, 2'h2, 8'h44, 2);
    check({7'h00, auto_ch2}, 8'h01);
    check({2'h0, pu_sw}, 8'h02);
    check({1'b0, pd_sw}, 8'h7D);
    fire(2'b10, OUT_GROUND, 2'h0, 8'h55, 0);
    check({2'h0, pu_sw}, 8'h01);
    @(posedge clock);
    auto_en <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check({2'h0, pu_sw}, 8'h3F);
    check({1'b0, pd_sw}, 8'h00);
    // Every outcome on both channels, then channel 1, channel 2 or both at random
    for (int i = 0; i < 16; i++) begin
      v = (i < 4) ? 8'h03 : 8'(1 + $urandom_range(0, 2));
      fire(v[1:0], mdr_outcome_t'(i % 4), 2'($urandom), 8'($urandom), $urandom_range(0, 3));
      rd(OFS_CHAN1_FLAGS, got);
      check(got, exp_f[0]);
      rd(OFS_CHAN1_LEVEL, got);
      check(got, exp_l[0]);
      rd(OFS_CHAN2_FLAGS, got);
      check(got, exp_f[1]);
      rd(OFS_CHAN2_LEVEL, got);
      check(got, exp_l[1]);
    end
    // Mid-run reset clears selects and results
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rd(OFS_CHAN1_FLAGS, got);
    check(got, 8'h00);
    rd(OFS_PULLUP_SELECT, got);
    check(got, 8'h00);
    check({2'h0, pu_sw}, 8'h00);
    // Periodic requests while unattached, none while attached
    @(posedge clock);
    per_en <= 1'b1;
    unattached <= 1'b1;
    for (n = 1; n <= 12; n++) begin
      @(posedge clock);
      #1;
      if (meas_start === 1'b1) break;
    end
    check(8'(n >= PERIOD && n <= PERIOD + 1), 8'h01);
    @(posedge clock);
    #1;
    check({7'h00, meas_start}, 8'h00);
    for (n = 2; n <= 12; n++) begin
      @(posedge clock);
      #1;
      if (meas_start === 1'b1) break;
    end
    check(8'(n), 8'(PERIOD));
    @(posedge clock);
    unattached <= 1'b0;
    n = 0;
    repeat (3 * PERIOD) begin
      @(posedge clock);
      #1;
      if (meas_start !== 1'b0) n++;
    end
    check(8'(n), 8'h00);
    // Unattached but periodic mode off: still no requests
    @(posedge clock);
    per_en <= 1'b0;
    unattached <= 1'b1;
    n = 0;
    repeat (3 * PERIOD) begin
      @(posedge clock);
      #1;
      if (meas_start !== 1'b0) n++;
    end
    check(8'(n), 8'h00);
    end_of_test();
  end
endmodule
